// >>> core/twowire_client.v
// two-wire client interface with strap decode and write FIFO
`timescale 1ns/1ns
`default_nettype none
`include "twowire_defines.vh"

// ****************************************
// write FIFO
// ****************************************
module twowire_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wptr_q;
    reg [AW-1:0]    rptr_q;
    reg [AW:0]      count_q;
    wire            push = in_valid_i && in_ready_o;
    wire            pop  = out_valid_o && out_ready_i;

    assign in_ready_o  = (count_q != DEPTH[AW:0]);
    assign out_valid_o = (count_q != {(AW+1){1'b0}});
    assign out_data_o  = mem_q[rptr_q];

    always @(posedge clk_i) begin
        if (push) begin
            mem_q[wptr_q] <= in_data_i;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wptr_q  <= {AW{1'b0}};
            rptr_q  <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= rptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

// ****************************************
// client top
// ****************************************
module twowire_client #(
    parameter [`CNT_W-1:0] PWRUP_CYC    = `PWRUP_CYC,
    parameter [`CNT_W-1:0] LOW_TMO_CYC  = `LOW_TMO_CYC,
    parameter [`CNT_W-1:0] IDLE_TMO_CYC = `IDLE_TMO_CYC,
    parameter              FIFO_DEPTH   = 16,
    parameter              FIFO_AW      = 4
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [2:0]  comm_select_strap_i,
    input  wire        spi_cs_n_i,
    input  wire        twowire_clock_line_i,
    input  wire        sda_i,
    output wire        sda_o,
    output wire        sda_oe_o,
    input  wire        timeout_en_i,
    output reg  [1:0]  proto_o,
    output reg         ready_o,
    output wire        spi_sel_o,
    output reg  [7:0]  rd_addr_o,
    input  wire [7:0]  rd_data_i,
    output wire        wr_valid_o,
    input  wire        wr_ready_i,
    output wire [7:0]  wr_addr_o,
    output wire [7:0]  wr_data_o
);
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_DEV  = 3'h1;
    localparam [2:0] S_REG  = 3'h2;
    localparam [2:0] S_WDAT = 3'h3;
    localparam [2:0] S_TX   = 3'h4;
    localparam [2:0] S_SKIP = 3'h5;
    function [7:0] ptr_next(input [7:0] p);
        ptr_next = p + 8'h01;
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    reg        scl_m_q;
    reg        scl_s_q;
    reg        scl_p_q;
    reg        sda_m_q;
    reg        sda_s_q;
    reg        sda_p_q;
    reg        cs_m_q;
    reg        cs_s_q;
    reg  [2:0] strap_m_q;
    reg  [2:0] strap_s_q;

    always @(posedge clk_i) begin
        if (rst_i) begin
            scl_m_q   <= 1'b1;
            scl_s_q   <= 1'b1;
            scl_p_q   <= 1'b1;
            sda_m_q   <= 1'b1;
            sda_s_q   <= 1'b1;
            sda_p_q   <= 1'b1;
            cs_m_q    <= 1'b1;
            cs_s_q    <= 1'b1;
            strap_m_q <= 3'h0;
            strap_s_q <= 3'h0;
        end else begin
            scl_m_q   <= twowire_clock_line_i;
            scl_s_q   <= scl_m_q;
            scl_p_q   <= scl_s_q;
            sda_m_q   <= sda_i;
            sda_s_q   <= sda_m_q;
            sda_p_q   <= sda_s_q;
            cs_m_q    <= spi_cs_n_i;
            cs_s_q    <= cs_m_q;
            strap_m_q <= comm_select_strap_i;
            strap_s_q <= strap_m_q;
        end
    end

    // host stretching just delays these edges; scl is never driven
    wire scl_rise  = scl_s_q && !scl_p_q;
    wire scl_fall  = !scl_s_q && scl_p_q;
    wire start_det = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
    wire stop_det  = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

    // ****************************************
    // power-up wait and strap capture
    // ****************************************
    reg [`CNT_W-1:0] pwr_cnt_q;
    reg [6:0]        dev_addr_q;

    always @(posedge clk_i) begin
        if (rst_i) begin
            pwr_cnt_q  <= {`CNT_W{1'b0}};
            ready_o    <= 1'b0;
            proto_o    <= `PROTO_SPI4;
            dev_addr_q <= `ADDR_VDD;
        end else if (!ready_o) begin
            // strap sampled at end of wait, once synchronised levels settled
            if (pwr_cnt_q == PWRUP_CYC - 1'b1) begin
                ready_o <= 1'b1;
                case (strap_s_q)
                    `STRAP_GND: proto_o <= `PROTO_SPI4;
                    `STRAP_56K: proto_o <= `PROTO_SPI3;
                    `STRAP_68K: proto_o <= `PROTO_LINK;
                    `STRAP_82K: begin
                        proto_o    <= `PROTO_TWOWIRE;
                        dev_addr_q <= `ADDR_82K;
                    end
                    `STRAP_100K: begin
                        proto_o    <= `PROTO_TWOWIRE;
                        dev_addr_q <= `ADDR_100K;
                    end
                    `STRAP_120K: begin
                        proto_o    <= `PROTO_TWOWIRE;
                        dev_addr_q <= `ADDR_120K;
                    end
                    `STRAP_150K: begin
                        proto_o    <= `PROTO_TWOWIRE;
                        dev_addr_q <= `ADDR_150K;
                    end
                    default: begin
                        proto_o    <= `PROTO_TWOWIRE;
                        dev_addr_q <= `ADDR_VDD;
                    end
                endcase
            end
            pwr_cnt_q <= pwr_cnt_q + 1'b1;
        end
    end

    wire active = ready_o && (proto_o == `PROTO_TWOWIRE);
    // chip select only reaches the SPI side
    assign spi_sel_o = ready_o && (proto_o != `PROTO_TWOWIRE) && (proto_o != `PROTO_LINK) && !cs_s_q;

    // ****************************************
    // bus timeouts
    // ****************************************
    reg [`CNT_W-1:0] low_cnt_q;
    reg [`CNT_W-1:0] idle_cnt_q;
    reg              tmo_q;

    always @(posedge clk_i) begin
        if (rst_i || !timeout_en_i) begin
            low_cnt_q  <= {`CNT_W{1'b0}};
            idle_cnt_q <= {`CNT_W{1'b0}};
            tmo_q      <= 1'b0;
        end else begin
            low_cnt_q  <= scl_s_q ? {`CNT_W{1'b0}} : low_cnt_q + 1'b1;
            idle_cnt_q <= (scl_s_q && sda_s_q) ? idle_cnt_q + 1'b1 : {`CNT_W{1'b0}};
            tmo_q      <= (low_cnt_q == LOW_TMO_CYC - 1'b1)
                       || (idle_cnt_q == IDLE_TMO_CYC);
        end
    end

    // ****************************************
    // write FIFO toward the register file
    // ****************************************
    reg        push_q;
    reg  [7:0] push_addr_q;
    reg  [7:0] push_data_q;
    wire       push_ready;

    // no stretching possible, so a full FIFO is answered by not acknowledging
    twowire_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (push_q),
        .in_ready_o  (push_ready),
        .in_data_i   ({push_addr_q, push_data_q}),
        .out_valid_o (wr_valid_o),
        .out_ready_i (wr_ready_i),
        .out_data_o  ({wr_addr_o, wr_data_o})
    );

    // ****************************************
    // byte engine
    // ****************************************
    reg [2:0] state_q;
    reg [2:0] next_q;
    reg [3:0] cnt_q;
    reg [7:0] shift_q;
    reg       oe_q;
    reg       host_nack_q;

    wire is_rx = (state_q == S_DEV) || (state_q == S_REG) || (state_q == S_WDAT);
    assign sda_o    = 1'b0;
    assign sda_oe_o = oe_q;

    always @(posedge clk_i) begin
        push_q <= 1'b0;
        if (rst_i) begin
            state_q     <= S_IDLE;
            next_q      <= S_IDLE;
            cnt_q       <= 4'h0;
            shift_q     <= 8'h00;
            oe_q        <= 1'b0;
            host_nack_q <= 1'b0;
            rd_addr_o   <= `PTR_RESET;
            push_addr_q <= 8'h00;
            push_data_q <= 8'h00;
        end else if (!active || stop_det || tmo_q) begin
            state_q <= S_IDLE;
            cnt_q   <= 4'h0;
            oe_q    <= 1'b0;
        end else if (start_det) begin
            state_q <= S_DEV;
            cnt_q   <= 4'h0;
            oe_q    <= 1'b0;
        end else if (scl_rise) begin
            if (is_rx && cnt_q < `BIT_LAST) begin
                shift_q <= {shift_q[6:0], sda_s_q};
                cnt_q   <= cnt_q + 1'b1;
            end else if (state_q == S_TX && cnt_q == `BIT_ACK) begin
                host_nack_q <= sda_s_q;
                if (!sda_s_q) begin
                    rd_addr_o <= ptr_next(rd_addr_o);
                end
            end
        end else if (scl_fall) begin
            if (is_rx && cnt_q == `BIT_LAST) begin
                cnt_q <= `BIT_ACK;
                case (state_q)
                    S_DEV: begin
                        if (shift_q[7:1] == dev_addr_q) begin
                            oe_q   <= 1'b1;
                            next_q <= shift_q[0] ? S_TX : S_REG;
                        end else begin
                            state_q <= S_SKIP;
                        end
                    end
                    S_REG: begin
                        rd_addr_o <= shift_q;
                        oe_q      <= 1'b1;
                        next_q    <= S_WDAT;
                    end
                    default: begin
                        if (push_ready) begin
                            push_q      <= 1'b1;
                            push_addr_q <= rd_addr_o;
                            push_data_q <= shift_q;
                            rd_addr_o   <= ptr_next(rd_addr_o);
                            oe_q        <= 1'b1;
                            next_q      <= S_WDAT;
                        end else begin
                            state_q <= S_SKIP;
                        end
                    end
                endcase
            end else if (is_rx && cnt_q == `BIT_ACK) begin
                state_q <= next_q;
                if (next_q == S_TX) begin
                    // read from current pointer, no address needed
                    shift_q <= rd_data_i;
                    oe_q    <= !rd_data_i[7];
                    cnt_q   <= `BIT_FIRST;
                end else begin
                    oe_q  <= 1'b0;
                    cnt_q <= 4'h0;
                end
            end else if (state_q == S_TX) begin
                if (cnt_q < `BIT_LAST) begin
                    oe_q    <= !shift_q[6];
                    shift_q <= {shift_q[6:0], 1'b0};
                    cnt_q   <= cnt_q + 1'b1;
                end else if (cnt_q == `BIT_LAST) begin
                    oe_q  <= 1'b0;
                    cnt_q <= `BIT_ACK;
                end else if (!host_nack_q) begin
                    shift_q <= rd_data_i;
                    oe_q    <= !rd_data_i[7];
                    cnt_q   <= `BIT_FIRST;
                end else begin
                    oe_q    <= 1'b0;
                    state_q <= S_SKIP;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> core/twowire_defines.vh
// constants for the two-wire client interface
`ifndef TWOWIRE_DEFINES_VH
`define TWOWIRE_DEFINES_VH

// ****************************************
// clock and timing
// ****************************************
`define CLK_KHZ        50000
`define CLK_MHZ        50
`define PWRUP_MS       15
`define LOW_TMO_MS     30
`define IDLE_TMO_US    200
`define PWRUP_CYC      (`PWRUP_MS * `CLK_KHZ)
`define LOW_TMO_CYC    (`LOW_TMO_MS * `CLK_KHZ)
`define IDLE_TMO_CYC   (`IDLE_TMO_US * `CLK_MHZ)
`define CNT_W          21

// ****************************************
// strap codes from the resistor decoder
// ****************************************
`define STRAP_GND      3'h0
`define STRAP_56K      3'h1
`define STRAP_68K      3'h2
`define STRAP_82K      3'h3
`define STRAP_100K     3'h4
`define STRAP_120K     3'h5
`define STRAP_150K     3'h6
`define STRAP_VDD      3'h7

// ****************************************
// protocol selection
// ****************************************
`define PROTO_SPI4     2'h0
`define PROTO_SPI3     2'h1
`define PROTO_LINK     2'h2
`define PROTO_TWOWIRE  2'h3

// ****************************************
// client addresses
// ****************************************
`define ADDR_82K       7'h2C
`define ADDR_100K      7'h2B
`define ADDR_120K      7'h2A
`define ADDR_150K      7'h29
`define ADDR_VDD       7'h28

// ****************************************
// bit counter marks and pointer reset value
// ****************************************
`define BIT_FIRST      4'h1
`define BIT_LAST       4'h8
`define BIT_ACK        4'h9
`define PTR_RESET      8'h00

`endif

// >>> test/twowire_client_bench.sv
// self-checking bench for the two-wire client
`timescale 1ns/1ns
`default_nettype none
module twowire_client_bench;
    logic       clk_i = 1'b0, rst_i = 1'b1, cs_n = 1'b1, ten = 1'b0;
    logic       stall = 1'b0, wr_ready = 1'b0;
    logic [2:0] strap = 3'h7;
    wire        scl, hsda, sda_o, oe, ready, spi_sel, wr_valid;
    wire [1:0]  proto;
    wire [7:0]  rd_addr, wr_addr, wr_data;
    wire [7:0]  rd_data = rd_addr ^ 8'h5A;
    wire        sda_line = hsda & ~oe;
    int         err_count = 0, check_count = 0, cyc = 0;
    logic [15:0] exp_q[$];
    twowire_client #(.PWRUP_CYC(21'd50), .LOW_TMO_CYC(21'd200), .IDLE_TMO_CYC(21'd100)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .comm_select_strap_i(strap), .spi_cs_n_i(cs_n),
        .twowire_clock_line_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(oe),
        .timeout_en_i(ten), .proto_o(proto), .ready_o(ready), .spi_sel_o(spi_sel),
        .rd_addr_o(rd_addr), .rd_data_i(rd_data), .wr_valid_o(wr_valid),
        .wr_ready_i(wr_ready), .wr_addr_o(wr_addr), .wr_data_o(wr_data));
    twowire_host host (.clk_i(clk_i), .scl_o(scl), .sda_o(hsda), .sda_i(sda_line));
    // ****************************************
    // clock, stimulus, monitor
    // ****************************************
    initial forever #10 clk_i = ~clk_i;
    // chip select toggles at random: it must not matter
    always @(negedge clk_i) begin
        cs_n <= 1'($urandom % 2);
        wr_ready <= !stall && ($urandom % 4 != 0);
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 100000) begin
            err_count++;
            wrap_up();
        end
    end
    always @(posedge clk_i)
        if (rst_i === 1'b0 && wr_valid === 1'b1 && wr_ready === 1'b1) begin
            if (exp_q.size() == 0) check(16'hFFFF, 16'h0000);
            else check({wr_addr, wr_data}, exp_q.pop_front());
        end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic do_reset(input logic [2:0] s);
        strap = s;
        rst_i = 1'b1;
        repeat (10) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_i);
        check(16'(ready), 16'h0);
        for (int i = 0; i < 100 && ready !== 1'b1; i++) @(negedge clk_i);
        repeat (4) @(negedge clk_i);
    endtask
    task automatic addr(input logic [7:0] b, input logic e);
        logic a;
        host.start();
        host.send(b, 8, a);
        check(16'(a), 16'(e));
    endtask
    task automatic wr_seq(input logic [7:0] r, input int n, input int ok);
        logic a;
        logic [7:0] d;
        addr(8'h50, 1'b0);
        host.send(r, 8, a);
        check(16'(a), 16'h0);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            // noted before sending: the word can leave the FIFO during the ack clock
            if (i < ok) exp_q.push_back({r + 8'(i), d});
            host.send(d, 8, a);
            check(16'(a), 16'(i >= ok));
        end
        host.stop();
    endtask
    task automatic rd_seq(input logic [7:0] r, input int n, input logic set);
        logic a;
        logic [7:0] b;
        if (set) begin
            addr(8'h50, 1'b0);
            host.send(r, 8, a);
            check(16'(a), 16'h0);
        end
        addr(8'h51, 1'b0);
        for (int i = 0; i < n; i++) begin
            host.recv(i == n - 1, b);
            check(16'(b), 16'(8'(r + 8'(i)) ^ 8'h5A));
        end
        host.stop();
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        logic [7:0] r;
        logic a;
        void'($urandom(22));
        for (int s = 0; s < 8; s++) begin
            do_reset(3'(s));
            check(16'(ready), 16'h1);
            check(16'(proto), 16'(s < 3 ? s : 3));
            if (s > 1) check(16'(spi_sel), 16'h0);
            if (s > 2) addr({7'h2C - 7'(s - 3), 1'b0}, 1'b0);
            else addr(8'h50, 1'b1);
            host.stop();
        end
        $display("test strap done");
        r = 8'($urandom);
        wr_seq(r, 1, 1);
        check(16'(rd_addr), 16'(8'(r + 8'h01)));
        wr_seq(8'hFE, 3, 3);
        $display("test write done");
        r = 8'($urandom);
        addr(8'h50, 1'b0);
        host.send(r, 8, a);
        host.stop();
        check(16'(rd_addr), 16'(r));
        rd_seq(r, 1, 1'b0);
        rd_seq(r, 1, 1'b0);
        rd_seq(8'($urandom), 1, 1'b1);
        rd_seq(8'hFF, 3, 1'b1);
        check(16'(rd_addr), 16'h0001);
        $display("test read done");
        addr(8'h58, 1'b1);
        host.send(8'($urandom), 8, a);
        check(16'(a), 16'h1);
        host.stop();
        stall = 1'b1;
        wr_seq(8'($urandom), 17, 16);
        stall = 1'b0;
        $display("test refuse done");
        for (int e = 0; e < 2; e++) begin
            ten = 1'(e);
            r = 8'($urandom);
            addr(8'h50, 1'b0);
            host.send(r, 8, a);
            host.pause(1'b0, 250);
            if (e == 0) exp_q.push_back({r, 8'hA5});
            host.send(8'hA5, 8, a);
            check(16'(a), 16'(e));
            host.stop();
            addr(8'h50, 1'b0);
            host.pause(1'b1, 150);
            host.send(8'h00, 7, a);
            check(16'(a), 16'(e));
            host.stop();
        end
        ten = 1'b0;
        $display("test timeout done");
        repeat (50) @(negedge clk_i);
        check(16'(exp_q.size()), 16'h0);
        wrap_up();
    end
endmodule
`default_nettype wire

// >>> test/twowire_client_properties.sv
// port assertions for the two-wire client
`timescale 1ns/1ns
`default_nettype none
`include "twowire_defines.vh"
module twowire_client_properties (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       twowire_clock_line_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic [1:0] proto_o,
    input wire logic       ready_o,
    input wire logic       spi_sel_o,
    input wire logic [7:0] rd_addr_o,
    input wire logic       wr_valid_o,
    input wire logic       wr_ready_i,
    input wire logic [7:0] wr_addr_o,
    input wire logic [7:0] wr_data_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ****************************************
    // reset, mode, bus drive, write port and pointer
    // ****************************************
    sequence s_oe_rise; $rose(sda_oe_o); endsequence
    sequence s_oe_held; sda_oe_o [*8]; endsequence
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
        !sda_oe_o && !ready_o && rd_addr_o == 8'h00 && !wr_valid_o && !spi_sel_o)
        else $error("outputs not quiet after reset");
    a_quiet_early: assert property (!ready_o |-> !sda_oe_o)
        else $error("bus driven before ready");
    a_ready_holds: assert property (ready_o |=> ready_o)
        else $error("ready dropped");
    a_proto_fixed: assert property (ready_o && $past(ready_o) |-> $stable(proto_o))
        else $error("protocol changed while running");
    a_spi_mode: assert property (spi_sel_o |-> ready_o && proto_o <= `PROTO_SPI3)
        else $error("spi select outside spi mode");
    a_other_quiet: assert property (ready_o && proto_o != `PROTO_TWOWIRE |-> !sda_oe_o)
        else $error("bus driven outside two-wire mode");
    a_pull_only: assert property (sda_o == 1'b0)
        else $error("data line driven high");
    // a change while the clock is high would look like a start or stop
    a_oe_clock_low: assert property ($changed(sda_oe_o) |-> !twowire_clock_line_i)
        else $error("data drive changed with clock high");
    a_oe_holds: assert property (s_oe_rise |-> s_oe_held)
        else $error("data drive dropped early");
    a_wr_stable: assert property (wr_valid_o && !wr_ready_i |=>
        wr_valid_o && $stable({wr_addr_o, wr_data_o}))
        else $error("write word moved while stalled");
    a_wr_rise_low: assert property ($rose(wr_valid_o) |-> !twowire_clock_line_i)
        else $error("write word outside low clock");
    a_ptr_mode: assert property ($changed(rd_addr_o) |-> proto_o == `PROTO_TWOWIRE)
        else $error("pointer moved outside two-wire mode");
endmodule
bind twowire_client twowire_client_properties u_props (
    .clk_i(clk_i), .rst_i(rst_i), .twowire_clock_line_i(twowire_clock_line_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .proto_o(proto_o), .ready_o(ready_o),
    .spi_sel_o(spi_sel_o), .rd_addr_o(rd_addr_o), .wr_valid_o(wr_valid_o),
    .wr_ready_i(wr_ready_i), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o));
`default_nettype wire

// >>> test/twowire_host.sv
// host controller model for the two-wire bus
`timescale 1ns/1ns
`default_nettype none
module twowire_host #(
    parameter int H = 63
) (
    input  wire logic clk_i,
    output var logic  scl_o,
    output var logic  sda_o,
    input  wire logic sda_i
);
    // ****************************************
    // bus primitives, half period H cycles
    // ****************************************
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // clock stands high between frames, under 400 kHz
    task automatic start();
        if (!scl_o) begin
            sda_o = 1'b1;
            wt(H);
            scl_o = 1'b1;
            wt(H);
        end
        sda_o = 1'b0;
        wt(H);
        scl_o = 1'b0;
        wt(H);
    endtask
    task automatic stop();
        sda_o = 1'b0;
        wt(H);
        scl_o = 1'b1;
        wt(H);
        sda_o = 1'b1;
        wt(H);
    endtask
    task automatic bit_x(input logic b, output logic s);
        sda_o = b;
        wt(H);
        scl_o = 1'b1;
        wt(H / 2);
        s = sda_i;
        wt(H - H / 2);
        scl_o = 1'b0;
    endtask
    // top n bits msb first, then the acknowledge clock
    task automatic send(input logic [7:0] b, input int n, output logic a);
        logic s;
        for (int i = 7; i > 7 - n; i--) bit_x(b[i], s);
        bit_x(1'b1, a);
    endtask
    task automatic recv(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
        bit_x(last, s);
    endtask
    // host may hold the clock at either level
    task automatic pause(input logic lvl, input int n);
        sda_o = 1'b1;
        wt(H);
        scl_o = lvl;
        wt(n);
        scl_o = 1'b0;
    endtask
endmodule
`default_nettype wire
